// ---- core/reset_ctrl_consts.vh ----
// Constants for the reset, default and wake pin controller.
`ifndef RESET_CTRL_CONSTS_VH
`define RESET_CTRL_CONSTS_VH
`define CLK_HZ            50000000
`define REBOOT_PULSE_MS   200
`define DEFAULT_HOLD_MS   6000
`define LAMP_BLINK_MS     5000
`define LAMP_HALF_MS      500
`define NUM_CFG_PINS      8
`define PIN_IRQ           1
`define PIN_MISO          2
`define PIN_MOSI          3
`define PIN_SCLK          6
`define PIN_CS            7
`define CFG_DIR_RESET     8'h00
`endif

// ---- core/pin_sync.v ----
// Two-flop synchroniser for one asynchronous pin.
`timescale 1ns/100ps
module pin_sync #(
	parameter RESET_VAL = 1'b1
) (
	input  wire clk_sys_in,
	input  wire rst_in,
	input  wire pin_in,
	output reg  sync_out
);
	reg meta;

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			meta     <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta     <= pin_in;
			sync_out <= meta;
		end
	end
endmodule // pin_sync

// ---- core/module_reset_default_wake_ctrl.v ----
// Reset, factory-default, wake and configurable pin controller.
`timescale 1ns/100ps
`include "reset_ctrl_consts.vh"
module module_reset_default_wake_ctrl #(
	parameter WIRELESS   = 1'b1,
	parameter PULSE_CYC  = `CLK_HZ / 1000 * `REBOOT_PULSE_MS,
	parameter HOLD_CYC   = `CLK_HZ / 1000 * `DEFAULT_HOLD_MS,
	parameter BLINK_CYC  = `CLK_HZ / 1000 * `LAMP_BLINK_MS,
	parameter HALF_CYC   = `CLK_HZ / 1000 * `LAMP_HALF_MS
) (
	input  wire       clk_sys_in,
	input  wire       rst_in,
	input  wire       hw_reboot_n_in,
	input  wire       default_n_in,
	input  wire       wake_in,
	input  wire       sleep_req_in,
	input  wire       spi_en_in,
	input  wire [7:0] cfg_dir_in,
	input  wire [7:0] cfg_dout_in,
	input  wire [7:0] cfg_pin_n_in,
	input  wire       spi_miso_in,
	input  wire       spi_sclk_in,
	input  wire       spi_cs_n_in,
	output reg  [7:0] cfg_pin_n_out,
	output reg  [7:0] cfg_pin_n_oe_out,
	output reg  [7:0] cfg_pin_n_sync_out,
	output reg        cfg_pin_irq_out,
	output reg        spi_mosi_out,
	output reg        cpu_reset_out,
	output reg        factory_restore_out,
	output reg        cli_default_boot_out,
	output reg        low_power_out,
	output reg        sys_status_lamp_out
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	wire       reboot_n_s;
	wire       default_n_s;
	wire       wake_s;
	wire [7:0] pins_s;

	pin_sync u_sync_reboot (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.pin_in(hw_reboot_n_in), .sync_out(reboot_n_s));
	pin_sync u_sync_default (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.pin_in(default_n_in), .sync_out(default_n_s));
	pin_sync u_sync_wake (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.pin_in(wake_in), .sync_out(wake_s));

	genvar g;
	generate
		for (g = 0; g < `NUM_CFG_PINS; g = g + 1) begin : g_pin
			pin_sync u_sync (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
				.pin_in(cfg_pin_n_in[g]), .sync_out(pins_s[g]));
		end
	endgenerate

	// ------------------------------------------------------------
	// Configurable pins
	// ------------------------------------------------------------
	reg [7:0] next_oe;
	reg [7:0] next_dout;

	always @* begin
		next_oe   = cfg_dir_in;
		next_dout = cfg_dout_in;
		if (WIRELESS && spi_en_in) begin
			next_oe[`PIN_IRQ]    = 1'b0;
			next_oe[`PIN_MISO]   = 1'b1;
			next_dout[`PIN_MISO] = spi_miso_in;
			next_oe[`PIN_MOSI]   = 1'b0;
			next_oe[`PIN_SCLK]   = 1'b0;
			next_oe[`PIN_CS]     = 1'b0;
		end
	end

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_pin_n_oe_out   <= `CFG_DIR_RESET;
			cfg_pin_n_out      <= 8'h00;
			cfg_pin_n_sync_out <= 8'hff;
			cfg_pin_irq_out    <= 1'b1;
			spi_mosi_out       <= 1'b0;
		end else if (cpu_reset_out) begin
			cfg_pin_n_oe_out   <= `CFG_DIR_RESET;
			cfg_pin_n_out      <= 8'h00;
			cfg_pin_n_sync_out <= pins_s;
			cfg_pin_irq_out    <= pins_s[`PIN_IRQ];
			spi_mosi_out       <= 1'b0;
		end else begin
			cfg_pin_n_oe_out   <= next_oe;
			cfg_pin_n_out      <= next_dout;
			cfg_pin_n_sync_out <= pins_s;
			cfg_pin_irq_out    <= pins_s[`PIN_IRQ];
			spi_mosi_out       <= (WIRELESS && spi_en_in) ? pins_s[`PIN_MOSI] : 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Reboot pulse and default button
	// ------------------------------------------------------------
	reg [31:0] pulse_cnt;
	reg [31:0] hold_cnt;
	reg [31:0] blink_cnt;
	reg        reboot_n_d;
	reg        held;
	reg        default_d;
	reg        wake_d;

	wire reboot_rise = reboot_n_s & ~reboot_n_d;
	wire soft_reboot = held & default_n_s;

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reboot_n_d           <= 1'b1;
			pulse_cnt            <= 32'h00000000;
			cpu_reset_out        <= 1'b1;
			hold_cnt             <= 32'h00000000;
			held                 <= 1'b0;
			factory_restore_out  <= 1'b0;
			cli_default_boot_out <= 1'b0;
			default_d            <= 1'b1;
			blink_cnt            <= 32'h00000000;
			sys_status_lamp_out  <= 1'b1;
		end else begin
			reboot_n_d <= reboot_n_s;
			default_d  <= default_n_s;
			if (!reboot_n_s) begin
				cpu_reset_out <= 1'b1;
				pulse_cnt     <= 32'h00000000;
			end else if (reboot_rise || soft_reboot) begin
				cpu_reset_out <= 1'b1;
				pulse_cnt     <= 32'h00000000;
			end else if (cpu_reset_out) begin
				if (pulse_cnt >= PULSE_CYC - 1)
					cpu_reset_out <= 1'b0;
				else
					pulse_cnt <= pulse_cnt + 32'h00000001;
			end
			if (reboot_rise) begin
				cli_default_boot_out <= WIRELESS & ~default_n_s;
				factory_restore_out  <= ~WIRELESS & ~default_n_s;
			end else if (soft_reboot) begin
				factory_restore_out  <= 1'b1;
				cli_default_boot_out <= 1'b0;
			end
			if (default_n_s || cpu_reset_out) begin
				hold_cnt <= 32'h00000000;
				held     <= 1'b0;
			end else if (hold_cnt >= HOLD_CYC - 1) begin
				held <= 1'b1;
			end else begin
				hold_cnt <= hold_cnt + 32'h00000001;
			end
			if (!default_n_s && !cpu_reset_out && hold_cnt >= BLINK_CYC - 1) begin
				if (blink_cnt >= HALF_CYC - 1) begin
					blink_cnt           <= 32'h00000000;
					sys_status_lamp_out <= ~sys_status_lamp_out;
				end else begin
					blink_cnt <= blink_cnt + 32'h00000001;
				end
			end else begin
				blink_cnt           <= 32'h00000000;
				sys_status_lamp_out <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Sleep and wake
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wake_d        <= 1'b1;
			low_power_out <= 1'b0;
		end else begin
			wake_d <= wake_s;
			if (cpu_reset_out || !WIRELESS)
				low_power_out <= 1'b0;
			else if (wake_s && !wake_d)
				low_power_out <= 1'b0;
			else if (sleep_req_in && !wake_s)
				low_power_out <= 1'b1;
		end
	end
endmodule // module_reset_default_wake_ctrl

// ---- bench/reset_ctrl_chk.sv ----
// Assertion checker for the reset, default and wake controller.
`timescale 1ns/100ps
module reset_ctrl_chk #(parameter PULSE_CYC = 20) (
	input wire       clk_sys_in, rst_in, hw_reboot_n_in, wake_in, spi_en_in, spi_miso_in,
	input wire [7:0] cfg_pin_n_in, cfg_pin_n_out, cfg_pin_n_oe_out,
	input wire       cfg_pin_irq_out, spi_mosi_out, cpu_reset_out, factory_restore_out,
	input wire       low_power_out
);
	reg [15:0] hi_cnt;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Counts reset cycles since the reboot pin went high.
	always @(posedge clk_sys_in or posedge rst_in)
		if (rst_in || !hw_reboot_n_in || !cpu_reset_out) hi_cnt <= 16'h0000;
		else hi_cnt <= hi_cnt + 16'h0001;
	a_dir_held: assert property (cpu_reset_out && $past(cpu_reset_out)
		|-> cfg_pin_n_oe_out == 8'h00) else $error("pin driven in reset");
	a_reboot_force: assert property (!hw_reboot_n_in [*4] |-> cpu_reset_out)
		else $error("reboot pin ignored");
	a_pulse_len: assert property ($fell(cpu_reset_out)
		|-> hi_cnt >= PULSE_CYC - 1 && hi_cnt <= PULSE_CYC + 5) else $error("pulse length");
	a_wake_block: assert property (wake_in [*4] |-> !low_power_out)
		else $error("sleep with wake high");
	a_irq_route: assert property ($stable(cfg_pin_n_in[1]) [*6]
		|-> cfg_pin_irq_out == cfg_pin_n_in[1]) else $error("irq route");
	a_mosi_route: assert property ((spi_en_in && !cpu_reset_out && $stable(cfg_pin_n_in[3])) [*6]
		|-> spi_mosi_out == cfg_pin_n_in[3]) else $error("mosi route");
	a_miso_drive: assert property ((spi_en_in && !cpu_reset_out && $stable(spi_miso_in)) [*4]
		|-> cfg_pin_n_oe_out[2] && cfg_pin_n_out[2] == spi_miso_in) else $error("miso");
	a_restore_boot: assert property ($rose(factory_restore_out)
		|-> ##[0:2] cpu_reset_out) else $error("restore without reboot");
endmodule // reset_ctrl_chk
bind module_reset_default_wake_ctrl reset_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) reset_ctrl_chk_i (.*);

// ---- bench/board_model.sv ----
// Board model of the buttons and pin loads facing the controller.
`timescale 1ns/100ps
module board_model (
	input  wire       clk_sys_in,
	input  wire [7:0] cfg_pin_n_out, cfg_pin_n_oe_out,
	output reg        hw_reboot_n_in = 1'b1,
	output reg        default_n_in = 1'b1,
	output reg        wake_in = 1'b1,
	output wire [7:0] cfg_pin_n_in
);
	reg [7:0] ext = 8'hff;
	// Driven pins show the controller's data, the others the board level.
	assign cfg_pin_n_in = (cfg_pin_n_oe_out & cfg_pin_n_out) | (~cfg_pin_n_oe_out & ext);
	task drive(input [2:0] lvl, input [7:0] e);
		@(posedge clk_sys_in);
		{wake_in, default_n_in, hw_reboot_n_in} <= lvl;
		ext <= e;
	endtask
endmodule // board_model

// ---- bench/test_module_reset_default_wake_ctrl.sv ----
// Self-checking bench for the reset, default and wake controller.
`timescale 1ns/100ps
module test_module_reset_default_wake_ctrl;
	localparam P = 20, H = 60;
	reg         clk_sys_in = 1'b0, rst_in = 1'b1, sleep_req_in = 1'b0, spi_en_in = 1'b0;
	reg         spi_miso_in = 1'b0, fr_e = 1'b0, cli_e = 1'b0, lp_e = 1'b0, chk = 1'b0;
	reg  [7:0]  cfg_dir_in = 8'h00, cfg_dout_in = 8'h00, e = 8'hff;
	reg  [16:0] lf = 17'h1377c;
	reg  [21:0] x;
	reg  [21:0] q[$];
	wire        spi_sclk_in = 1'b0, spi_cs_n_in = 1'b1;
	wire        hw_reboot_n_in, default_n_in, wake_in, cfg_pin_irq_out, spi_mosi_out;
	wire        cpu_reset_out, factory_restore_out, cli_default_boot_out, low_power_out;
	wire        sys_status_lamp_out;
	wire [7:0]  cfg_pin_n_in, cfg_pin_n_out, cfg_pin_n_oe_out, cfg_pin_n_sync_out;
	integer     error_cnt = 0, cmp_count = 0, lamp_tog = 0;
	reg         lamp_d = 1'b1;
	always @(posedge clk_sys_in) begin
		lamp_d <= sys_status_lamp_out;
		if (!rst_in && sys_status_lamp_out !== lamp_d) lamp_tog = lamp_tog + 1;
	end
	wire [21:0] seen = {cfg_pin_n_oe_out, cfg_pin_n_oe_out & cfg_pin_n_out, cpu_reset_out,
		factory_restore_out, cli_default_boot_out, low_power_out, cfg_pin_irq_out,
		spi_en_in & spi_mosi_out};
	module_reset_default_wake_ctrl #(.PULSE_CYC(P), .HOLD_CYC(H), .BLINK_CYC(50), .HALF_CYC(4))
		module_reset_default_wake_ctrl_i (.*);
	board_model board_model_i (.*);
	initial forever #10 clk_sys_in = ~clk_sys_in;
	function [16:0] nx(input [16:0] v);
		nx = {v[15:0], v[16] ^ v[13]};
	endfunction
	task check(input c);
		reg [7:0] o;
		begin
			o = c ? 8'h00 : (spi_en_in ? 8'h04 : cfg_dir_in);
			q.push_back({o, o & (spi_en_in ? {5'h00, spi_miso_in, 2'h0} : cfg_dout_in), c,
				fr_e, cli_e, lp_e, o[1] ? cfg_dout_in[1] : e[1], spi_en_in & e[3]});
			chk <= 1'b1;
			@(posedge clk_sys_in);
			chk <= 1'b0;
		end
	endtask
	task pins(input [2:0] lvl, input integer n);
		board_model_i.drive(lvl, e);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task results;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) if (chk) begin
		x = q.pop_front();
		cmp_count = cmp_count + 1;
		if (x !== seen) begin
			error_cnt = error_cnt + 1;
			$display("ERROR outputs expected %h seen %h", x, seen);
		end
	end
	initial begin
		repeat (1000) @(posedge clk_sys_in);
		error_cnt = error_cnt + 1;
		results;
	end
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (P + 8) @(posedge clk_sys_in);
		check(1'b0);
		repeat (4) begin
			lf = nx(nx(lf));
			cfg_dir_in <= lf[7:0];
			cfg_dout_in <= lf[15:8];
			e = lf[16:9];
			pins(3'b111, 6);
			check(1'b0);
		end
		$display("test pins done");
		spi_en_in <= 1'b1;
		spi_miso_in <= lf[0];
		cfg_dir_in <= 8'h00;
		pins(3'b111, 6);
		check(1'b0);
		spi_en_in <= 1'b0;
		cfg_dir_in <= 8'hff;
		pins(3'b110, 8);
		check(1'b1);
		cmp_count = cmp_count + 1;
		if (cfg_pin_n_sync_out !== e) begin
			error_cnt = error_cnt + 1;
			$display("ERROR cfg_pin_n_sync_out expected %h seen %h", e, cfg_pin_n_sync_out);
		end
		pins(3'b111, P + 8);
		check(1'b0);
		$display("test reboot done");
		cmp_count = cmp_count + 1;
		if (lamp_tog !== 0) begin
			error_cnt = error_cnt + 1;
			$display("ERROR lamp toggles expected 0 seen %0d", lamp_tog);
		end
		pins(3'b101, H + 10);
		cmp_count = cmp_count + 1;
		if (lamp_tog < 2) begin
			error_cnt = error_cnt + 1;
			$display("ERROR lamp toggles expected at least 2 seen %0d", lamp_tog);
		end
		pins(3'b111, 8);
		fr_e = 1'b1;
		check(1'b1);
		pins(3'b100, 5);
		pins(3'b101, P + 8);
		fr_e = 1'b0;
		cli_e = 1'b1;
		check(1'b0);
		$display("test default done");
		sleep_req_in <= 1'b1;
		pins(3'b011, 6);
		lp_e = 1'b1;
		check(1'b0);
		pins(3'b111, 6);
		lp_e = 1'b0;
		check(1'b0);
		$display("test wake done");
		results;
	end
endmodule // test_module_reset_default_wake_ctrl
